// ---- rtl/imp_clk_div.sv ----
// Phase tick divider: four ticks per serial clock period
`timescale 1ns/100ps
module imp_clk_div
  import imp_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic en,
  input wire logic base_sel,
  input wire logic [3:0] presc,
  output logic tick
);
  logic [6:0] pre_q, pre_d;
  logic [3:0] scale_q, scale_d;
  logic tick_q, tick_d;
  logic pre_wrap, scale_wrap;

  always_comb begin
    // Compare with >= so a setting change mid-count cannot overrun
    pre_wrap = pre_q >= (base_sel ? PRE_SLOW_MAX : PRE_FAST_MAX);
    scale_wrap = scale_q >= presc;
    pre_d = (!en || pre_wrap) ? 7'h00 : pre_q + 7'h01;
    scale_d = scale_q;
    if (!en) begin
      scale_d = 4'h0;
    end else if (pre_wrap) begin
      scale_d = scale_wrap ? 4'h0 : scale_q + 4'h1;
    end
    tick_d = en && pre_wrap && scale_wrap;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pre_q <= 7'h00;
      scale_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      scale_q <= scale_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : imp_clk_div

// ---- rtl/imp_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module imp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clock,
  input wire logic rstn,
  imp_fifo_if.fifo_side port
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [W-1:0] mem_d [D];
  logic [AW:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic full, empty, wr, rd;

  always_comb begin
    empty = wptr_q == rptr_q;
    full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
    wr = port.push_valid && !full;
    rd = port.pop_ready && !empty;
    wptr_d = wr ? wptr_q + 1'b1 : wptr_q;
    rptr_d = rd ? rptr_q + 1'b1 : rptr_q;
  end

  for (genvar i = 0; i < D; i++) begin : g_entry
    always_comb begin
      mem_d[i] = (wr && wptr_q[AW-1:0] == AW'(i)) ? port.push_data : mem_q[i];
    end
    always_ff @(posedge clock) begin
      if (!rstn) begin
        mem_q[i] <= '0;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
    end
  end

  assign port.push_ready = !full;
  assign port.pop_valid = !empty;
  assign port.pop_data = mem_q[rptr_q[AW-1:0]];

  a_fifo_full_hold: assert property (@(posedge clock) disable iff (!rstn)
    full && !rd |=> $stable(wptr_q) && !port.push_ready) else $error("fifo overfilled");
endmodule : imp_fifo

// ---- rtl/imp_fifo_if.sv ----
// Push and pop signals between the port and its receive FIFO
`timescale 1ns/100ps
interface imp_fifo_if #(parameter int W = 8);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport fifo_side(input push_valid, input push_data, input pop_ready,
                    output push_ready, output pop_valid, output pop_data);
  modport user_side(output push_valid, output push_data, output pop_ready,
                    input push_ready, input pop_valid, input pop_data);
endinterface : imp_fifo_if

// ---- rtl/imp_pkg.sv ----
// Shared constants and types of the multi-master two-wire serial port
package imp_pkg;
  localparam logic [7:0] CLK_CTRL_ADDR = 8'hf0;
  localparam logic [7:0] BUS_STAT_ADDR = 8'hf1;
  localparam logic [7:0] DATA_ADDR = 8'hf2;
  localparam logic [7:0] OWN_ADDR_ADDR = 8'hf3;
  localparam logic [7:0] CLK_CTRL_RST = 8'h0f;
  localparam logic [7:0] BUS_STAT_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam int CC_ACK_EN = 7;
  localparam int CC_BASE_SEL = 6;
  localparam int CC_IRQ_EN = 5;
  localparam int CC_PEND = 4;
  localparam int BS_MODE_HI = 7;
  localparam int BS_MODE_LO = 6;
  localparam int BS_BUSY = 5;
  localparam int BS_EN = 4;
  localparam int BS_ARB = 3;
  localparam int BS_AM = 2;
  localparam int BS_GC = 1;
  localparam int BS_RXACK = 0;
  localparam int PHASES = 4;
  localparam int BASE_DIV_FAST = 16;
  localparam int BASE_DIV_SLOW = 512;
  localparam logic [6:0] PRE_FAST_MAX = 7'(BASE_DIV_FAST / PHASES - 1);
  localparam logic [6:0] PRE_SLOW_MAX = 7'(BASE_DIV_SLOW / PHASES - 1);
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_START = 6'h02, ST_MBIT = 6'h04,
    ST_HOLD = 6'h08, ST_STOP = 6'h10, ST_SBIT = 6'h20
  } imp_state_t;
endpackage : imp_pkg

// ---- rtl/imp_port.sv ----
// Multi-master two-wire serial port: registers, bus engine and receive buffer
`timescale 1ns/100ps
// Notes on behaviour
// - Clock control bit 7 enables driving acknowledge; 0 leaves it released.
// - Clock control bit 6 picks base clock: oscillator over 16 or over 512.
// - Clock control bit 5 gates the pending request onto the CPU request line.
// - Clock control bit 4 reads pending; writing 0 clears it.
// - Serial clock is base clock over prescaler field plus one; field resets ones.
// - Status bits 7:6 pick slave rx, slave tx, master rx, master tx.
// - Status bit 5 reads 1 while the bus is busy.
// - Writing 0 to status bit 5 issues a stop condition.
// - Status bit 4 at 0 stops all transmit and receive on the bus.
// - Arbitration loss as master transmitter sets status bit 3.
// - In slave mode, irq enable with no address match sets status bit 3.
// - Status bit 2 sets on own address or general call; start, stop clear.
// - Status bit 1 sets on all-zero address; start or stop clears it.
// - Status bit 0 captures the received acknowledge, 1 meaning none.
module imp_port
  import imp_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  output logic irq_req,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  imp_fifo_if #(.W(FIFO_W)) rx_if ();

  logic [7:0] cc_q, cc_d, bs_q, bs_d, tx_q, tx_d, own_q, own_d, rdata_q, rdata_d;
  logic busy_q, busy_d;
  imp_state_t st_q, st_d;
  logic [1:0] phase_q, phase_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d;
  logic addr_q, addr_d, txb_q, txb_d, mst_q, mst_d;
  logic scl_low_q, scl_low_d, sda_low_q, sda_low_d, push_q, push_d;
  logic scl_prev_q, sda_prev_q;
  logic tick, start_det, stop_det, scl_rise, scl_fall;
  logic cmd_start, cmd_stop, mst_mode, enable, slave_arb;
  logic byte_done, am_set, gc_set, arb_set, ack_set, ack_val;
  logic [7:0] full_byte;

  imp_clk_div u_div (
    .clock(clock),
    .rstn(rstn),
    .en(enable),
    .base_sel(cc_q[CC_BASE_SEL]),
    .presc(cc_q[3:0]),
    .tick(tick)
  );

  imp_fifo #(.W(FIFO_W), .D(FIFO_D)) u_rx_fifo (
    .clock(clock),
    .rstn(rstn),
    .port(rx_if.fifo_side)
  );

  // Release (1) or drive low (0) for the current bit slot
  function automatic logic out_bit(input logic [3:0] b, input logic tx, input logic adr,
                                   input logic [7:0] sh, input logic ack_en,
                                   input logic am);
    if (b < BIT_ACK) begin
      out_bit = tx ? sh[7] : 1'b1;
    end else if (tx) begin
      out_bit = 1'b1;
    end else if (adr) begin
      out_bit = !(am && ack_en);
    end else begin
      out_bit = !ack_en;
    end
  endfunction : out_bit

  assign enable = bs_q[BS_EN];
  assign mst_mode = bs_q[BS_MODE_HI];
  assign start_det = scl_in && scl_prev_q && sda_prev_q && !sda_in;
  assign stop_det = scl_in && scl_prev_q && !sda_prev_q && sda_in;
  assign scl_rise = scl_in && !scl_prev_q;
  assign scl_fall = !scl_in && scl_prev_q;
  assign cmd_start = reg_we && reg_addr == BUS_STAT_ADDR && reg_wdata[BS_BUSY];
  assign cmd_stop = reg_we && reg_addr == BUS_STAT_ADDR && !reg_wdata[BS_BUSY];
  assign full_byte = {shift_q[6:0], sda_in};
  assign slave_arb = !bs_q[BS_MODE_HI] && cc_q[CC_IRQ_EN] && !bs_q[BS_AM];

  // Bus engine
  always_comb begin
    st_d = st_q;
    phase_d = phase_q;
    bit_d = bit_q;
    shift_d = shift_q;
    addr_d = addr_q;
    txb_d = txb_q;
    mst_d = mst_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    push_d = push_q && !rx_if.push_ready;
    byte_done = 1'b0;
    am_set = 1'b0;
    gc_set = 1'b0;
    arb_set = 1'b0;
    ack_set = 1'b0;
    ack_val = 1'b1;
    unique case (st_q)
      ST_IDLE: begin
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
        mst_d = 1'b0;
        if (cmd_start && mst_mode) begin
          if (busy_q) begin
            arb_set = 1'b1;
          end else begin
            st_d = ST_START;
            phase_d = 2'h0;
            mst_d = 1'b1;
          end
        end else if (start_det) begin
          st_d = ST_SBIT;
          bit_d = 4'h0;
          addr_d = 1'b1;
          txb_d = 1'b0;
        end
      end
      ST_START: if (tick) begin
        phase_d = phase_q + 2'h1;
        if (phase_q == 2'h0) begin
          scl_low_d = 1'b0;
          sda_low_d = 1'b0;
        end else if (phase_q == 2'h1) begin
          sda_low_d = 1'b1;
        end else if (phase_q == 2'h3) begin
          st_d = ST_MBIT;
          bit_d = 4'h0;
          addr_d = 1'b1;
          txb_d = 1'b1;
          shift_d = tx_q;
          scl_low_d = 1'b1;
        end
      end
      ST_MBIT: if (tick) begin
        unique case (phase_q)
          2'h0: begin
            sda_low_d = !out_bit(bit_q, txb_q, addr_q, shift_q, cc_q[CC_ACK_EN], 1'b0);
            phase_d = 2'h1;
          end
          2'h1: begin
            scl_low_d = 1'b0;
            phase_d = 2'h2;
          end
          2'h2: if (scl_in) begin
            // Waits here while a slave stretches the clock
            phase_d = 2'h3;
            if (bit_q < BIT_ACK) begin
              shift_d = full_byte;
            end
            if (txb_q && bit_q < BIT_ACK && !sda_low_q && !sda_in) begin
              arb_set = 1'b1;
              st_d = ST_IDLE;
              scl_low_d = 1'b0;
              sda_low_d = 1'b0;
            end
            if (txb_q && bit_q == BIT_ACK) begin
              ack_set = 1'b1;
              ack_val = sda_in;
            end
          end
          2'h3: begin
            scl_low_d = 1'b1;
            phase_d = 2'h0;
            if (bit_q == BIT_ACK) begin
              byte_done = 1'b1;
              push_d = !txb_q;
              sda_low_d = 1'b0;
              st_d = ST_HOLD;
            end else begin
              bit_d = bit_q + 4'h1;
            end
          end
        endcase
      end
      ST_HOLD: begin
        scl_low_d = 1'b1;
        if (mst_q && cmd_stop) begin
          st_d = ST_STOP;
          phase_d = 2'h0;
        end else if (mst_q && cmd_start) begin
          st_d = ST_START;
          phase_d = 2'h0;
        end else if (!mst_q && stop_det) begin
          st_d = ST_IDLE;
        end else if (!cc_q[CC_PEND] && !push_q) begin
          // Clock stays low until software and the buffer both let go
          bit_d = 4'h0;
          addr_d = 1'b0;
          txb_d = bs_q[BS_MODE_LO];
          shift_d = tx_q;
          if (mst_q) begin
            st_d = ST_MBIT;
          end else begin
            st_d = ST_SBIT;
            scl_low_d = 1'b0;
            sda_low_d = bs_q[BS_MODE_LO] && !tx_q[7];
          end
        end
      end
      ST_STOP: if (tick) begin
        phase_d = phase_q + 2'h1;
        if (phase_q == 2'h0) begin
          sda_low_d = 1'b1;
          scl_low_d = 1'b1;
        end else if (phase_q == 2'h1) begin
          scl_low_d = 1'b0;
        end else if (phase_q == 2'h2) begin
          sda_low_d = 1'b0;
        end else begin
          st_d = ST_IDLE;
        end
      end
      ST_SBIT: begin
        if (stop_det) begin
          st_d = ST_IDLE;
          sda_low_d = 1'b0;
        end else if (start_det) begin
          bit_d = 4'h0;
          addr_d = 1'b1;
          txb_d = 1'b0;
        end else if (scl_rise) begin
          bit_d = bit_q + 4'h1;
          if (bit_q < BIT_ACK) begin
            shift_d = full_byte;
          end
          if (addr_q && bit_q == 4'h7) begin
            am_set = full_byte[7:1] == own_q[7:1] || full_byte == GEN_CALL_ADDR;
            gc_set = full_byte == GEN_CALL_ADDR;
          end
          if (txb_q && bit_q == BIT_ACK) begin
            ack_set = 1'b1;
            ack_val = sda_in;
          end
        end else if (scl_fall) begin
          if (addr_q && bit_q == BIT_ACK && !bs_q[BS_AM]) begin
            st_d = ST_IDLE;
            sda_low_d = 1'b0;
          end else if (bit_q == BIT_END) begin
            byte_done = 1'b1;
            push_d = !addr_q && !txb_q;
            st_d = ST_HOLD;
            scl_low_d = 1'b1;
            sda_low_d = 1'b0;
          end else begin
            sda_low_d = !out_bit(bit_q, txb_q, addr_q, shift_q, cc_q[CC_ACK_EN],
                                 bs_q[BS_AM]);
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (!enable) begin
      st_d = ST_IDLE;
      scl_low_d = 1'b0;
      sda_low_d = 1'b0;
      push_d = 1'b0;
    end
  end

  // Register file
  always_comb begin
    cc_d = cc_q;
    bs_d = bs_q;
    tx_d = tx_q;
    own_d = own_q;
    rdata_d = rdata_q;
    busy_d = busy_q;
    if (reg_we && reg_addr == CLK_CTRL_ADDR) begin
      // Writing 1 to pending is ignored
      cc_d = {reg_wdata[7:5], cc_q[CC_PEND] & reg_wdata[CC_PEND], reg_wdata[3:0]};
    end
    if (byte_done) begin
      cc_d[CC_PEND] = 1'b1;
    end
    if (reg_we && reg_addr == BUS_STAT_ADDR) begin
      bs_d[7:6] = reg_wdata[7:6];
      bs_d[BS_EN] = reg_wdata[BS_EN];
      bs_d[BS_ARB] = reg_wdata[BS_ARB];
    end
    if (start_det || stop_det) begin
      bs_d[BS_AM] = 1'b0;
      bs_d[BS_GC] = 1'b0;
    end
    if (am_set) begin
      bs_d[BS_AM] = 1'b1;
    end
    if (gc_set) begin
      bs_d[BS_GC] = 1'b1;
    end
    if (arb_set || slave_arb) begin
      bs_d[BS_ARB] = 1'b1;
    end
    if (ack_set) begin
      bs_d[BS_RXACK] = ack_val;
    end
    bs_d[BS_BUSY] = 1'b0;
    if (start_det) begin
      busy_d = 1'b1;
    end else if (stop_det) begin
      busy_d = 1'b0;
    end
    if (reg_we && reg_addr == DATA_ADDR) begin
      tx_d = reg_wdata;
    end
    if (reg_we && reg_addr == OWN_ADDR_ADDR) begin
      own_d = reg_wdata;
    end
    if (reg_re) begin
      unique case (reg_addr)
        CLK_CTRL_ADDR: rdata_d = cc_q;
        BUS_STAT_ADDR: rdata_d = {bs_q[7:6], busy_q, bs_q[4:0]};
        DATA_ADDR: rdata_d = rx_if.pop_valid ? rx_if.pop_data : 8'h00;
        OWN_ADDR_ADDR: rdata_d = own_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cc_q <= CLK_CTRL_RST;
      bs_q <= BUS_STAT_RST;
      tx_q <= DATA_RST;
      own_q <= OWN_ADDR_RST;
      rdata_q <= 8'h00;
      busy_q <= 1'b0;
      st_q <= ST_IDLE;
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      addr_q <= 1'b0;
      txb_q <= 1'b0;
      mst_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      push_q <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      cc_q <= cc_d;
      bs_q <= bs_d;
      tx_q <= tx_d;
      own_q <= own_d;
      rdata_q <= rdata_d;
      busy_q <= busy_d;
      st_q <= st_d;
      phase_q <= phase_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      txb_q <= txb_d;
      mst_q <= mst_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      push_q <= push_d;
      scl_prev_q <= scl_in;
      sda_prev_q <= sda_in;
    end
  end

  assign rx_if.push_valid = push_q;
  assign rx_if.push_data = shift_q;
  assign rx_if.pop_ready = reg_re && reg_addr == DATA_ADDR;
  assign reg_rdata = rdata_q;
  assign irq_req = cc_q[CC_PEND] && cc_q[CC_IRQ_EN];
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = !scl_low_q;
  assign sda_oe_n = !sda_low_q;

  sequence s_start_cmd;
    cmd_start && mst_mode && enable && st_q == ST_IDLE && !busy_q;
  endsequence
  sequence s_byte_end;
    byte_done && enable;
  endsequence

  a_start_issue: assert property (@(posedge clock) disable iff (!rstn)
    s_start_cmd |=> st_q == ST_START && mst_q) else $error("start not issued");
  a_pend_set: assert property (@(posedge clock) disable iff (!rstn)
    s_byte_end |=> cc_q[CC_PEND] && st_q == ST_HOLD && !scl_oe_n) else $error("no pending hold");
  a_pend_clear: assert property (@(posedge clock) disable iff (!rstn)
    reg_we && reg_addr == CLK_CTRL_ADDR && !reg_wdata[CC_PEND] && !byte_done
    |=> !cc_q[CC_PEND]) else $error("pending not cleared");
  a_presc_reset: assert property (@(posedge clock)
    !rstn |=> cc_q == CLK_CTRL_RST) else $error("clock control reset wrong");
  a_irq_gate: assert property (@(posedge clock) disable iff (!rstn)
    !cc_q[CC_IRQ_EN] |-> !irq_req) else $error("request not gated");
  a_busy_start: assert property (@(posedge clock) disable iff (!rstn)
    start_det |=> busy_q && reg_rdata == $past(reg_rdata) || busy_q) else $error("busy missed");
  a_stop_clear: assert property (@(posedge clock) disable iff (!rstn)
    stop_det && !am_set |=> !busy_q && !bs_q[BS_AM] && !bs_q[BS_GC]) else $error("stop clear");
  a_disable_idle: assert property (@(posedge clock) disable iff (!rstn)
    !enable |=> st_q == ST_IDLE && scl_oe_n && sda_oe_n) else $error("disabled but active");
  a_arb_master: assert property (@(posedge clock) disable iff (!rstn)
    arb_set |=> bs_q[BS_ARB] && st_q == ST_IDLE) else $error("arbitration loss missed");
  a_slave_arb: assert property (@(posedge clock) disable iff (!rstn)
    slave_arb |=> bs_q[BS_ARB]) else $error("slave arbitration flag missed");
  a_gen_call: assert property (@(posedge clock) disable iff (!rstn)
    gc_set |=> bs_q[BS_GC] && bs_q[BS_AM]) else $error("general call missed");
  a_ack_cap: assert property (@(posedge clock) disable iff (!rstn)
    ack_set |=> bs_q[BS_RXACK] == $past(ack_val)) else $error("ack not captured");
  a_stop_cmd: assert property (@(posedge clock) disable iff (!rstn)
    enable && st_q == ST_HOLD && mst_q && cmd_stop |=> st_q == ST_STOP) else $error("no stop");
  a_ack_drive: assert property (@(posedge clock) disable iff (!rstn)
    enable && st_q == ST_SBIT && scl_fall && !start_det && !stop_det && !addr_q && !txb_q
    && bit_q == BIT_ACK |=> sda_low_q == $past(cc_q[CC_ACK_EN])) else $error("ack drive");
endmodule : imp_port

// ---- test/imp_bus_model.sv ----
// Behavioural far-side party: one-byte target and a plain bus master
`timescale 1ns/100ps
module imp_bus_model (
  input wire logic clock,
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  logic tgt_on = 1'b0;
  logic nack = 1'b0;
  logic [7:0] got = 8'h00;
  logic [7:0] sh = 8'h00;
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  // Target keeps one byte only; enough for single-byte master frames
  always begin
    @(negedge sda iff scl === 1'b1);
    if (tgt_on) begin
      repeat (8) begin
        @(posedge scl);
        sh = {sh[6:0], sda};
      end
      @(negedge scl);
      @(negedge clock);
      sda_oe_n = nack;
      @(negedge scl);
      @(negedge clock);
      sda_oe_n = 1'b1;
      got = sh;
    end
  end
  task automatic half();
    repeat (40) @(negedge clock);
  endtask : half
  // Waits for the line high, so a stretched clock is honoured
  task automatic m_bit(input logic b, output logic s);
    sda_oe_n = b;
    half();
    scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    half();
    s = sda;
    scl_oe_n = 1'b0;
  endtask : m_bit
  task automatic m_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) m_bit(b[i], s);
    m_bit(1'b1, ack);
    half();
  endtask : m_byte
  task automatic m_start();
    sda_oe_n = 1'b0;
    half();
    scl_oe_n = 1'b0;
  endtask : m_start
  task automatic m_stop();
    sda_oe_n = 1'b0;
    half();
    scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    half();
    sda_oe_n = 1'b1;
    half();
  endtask : m_stop
endmodule : imp_bus_model

// ---- test/testbench.sv ----
// Self-checking bench of the two-wire serial port
`timescale 1ns/100ps
module testbench;
  import imp_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata, rd;
  logic irq_req, scl_out, scl_oe_n, sda_out, sda_oe_n, m_scl_n, m_sda_n, ack;
  wire logic scl = scl_oe_n & m_scl_n;
  wire logic sda = sda_oe_n & m_sda_n;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int last_rise = 0;
  int per = 0;
  logic [23:0] rows [11] = '{24'hf03a2a, 24'hf10008, 24'hf00000, 24'hf10808, 24'hf12700,
    24'hf14040, 24'hf18080, 24'hf1c0c0, 24'hf35a5a, 24'hf97700, 24'hf0ffef};
  // Ctrl, data, no-ack flag, expected clock period in cycles
  logic [31:0] mt [3] = '{32'ha0a60010, 32'h815b1020, 32'hc0810200};
  // Ctrl, address, expected ack, expected match and general-call bits
  logic [23:0] sl [4] = '{24'h80b402, 24'h800003, 24'h803210, 24'h00b412};
  always #25 clock = ~clock;
  imp_port u_imp_port (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .irq_req(irq_req), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  imp_bus_model u_imp_bus_model (.clock(clock), .scl(scl), .sda(sda),
    .scl_oe_n(m_scl_n), .sda_oe_n(m_sda_n));
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Counted off the falling edge so the port's scl timing never races it
  always @(negedge clock) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  always @(posedge scl) begin
    per = cyc - last_rise;
    last_rise = cyc;
  end
  // Registers reached by their direct address only
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clock);
    reg_we = 1'b0;
  endtask : wr
  task automatic rr(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge clock);
    reg_re = 1'b0;
    d = reg_rdata;
  endtask : rr
  initial begin
    repeat (12) @(negedge clock);
    rstn = 1'b1;
    rr(CLK_CTRL_ADDR, rd);
    check(rd, 8'h0f);
    rr(BUS_STAT_ADDR, rd);
    check({irq_req, rd}, 9'h000);
    for (int i = 0; i < 11; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rr(rows[i][23:16], rd);
      check(rd, rows[i][7:0]);
    end
    for (int i = 0; i < 3; i++) begin
      u_imp_bus_model.tgt_on = 1'b1;
      u_imp_bus_model.nack = mt[i][12];
      // Enable first: a start is only taken once the port is already on
      wr(BUS_STAT_ADDR, 8'hd0);
      wr(CLK_CTRL_ADDR, mt[i][31:24]);
      wr(DATA_ADDR, mt[i][23:16]);
      wr(BUS_STAT_ADDR, 8'hf0);
      rd = 8'h00;
      for (int k = 0; k < 9000 && rd[CC_PEND] !== 1'b1; k++) rr(CLK_CTRL_ADDR, rd);
      check(12'(per), mt[i][11:0]);
      check(u_imp_bus_model.got, mt[i][23:16]);
      check(irq_req, mt[i][29]);
      rr(BUS_STAT_ADDR, rd);
      check({rd[BS_BUSY], rd[BS_RXACK]}, {1'b1, mt[i][12]});
      repeat (20) @(negedge clock);
      check(scl, 1'b0);
      wr(BUS_STAT_ADDR, 8'hd0);
      wr(CLK_CTRL_ADDR, mt[i][31:24]);
      rr(CLK_CTRL_ADDR, rd);
      check(rd[CC_PEND], 1'b0);
      rd = 8'hff;
      for (int k = 0; k < 3000 && rd[BS_BUSY] !== 1'b0; k++) rr(BUS_STAT_ADDR, rd);
      check({rd[BS_BUSY], scl, sda}, 3'b011);
    end
    wr(BUS_STAT_ADDR, 8'hc0);
    repeat (100) @(negedge clock);
    check({scl, sda}, 2'b11);
    u_imp_bus_model.tgt_on = 1'b0;
    wr(OWN_ADDR_ADDR, 8'hb4);
    wr(BUS_STAT_ADDR, 8'h10);
    for (int i = 0; i < 4; i++) begin
      wr(CLK_CTRL_ADDR, sl[i][23:16]);
      u_imp_bus_model.m_start();
      u_imp_bus_model.m_byte(sl[i][15:8], ack);
      check(ack, sl[i][4]);
      rr(BUS_STAT_ADDR, rd);
      check(rd[2:1], sl[i][1:0]);
      if (sl[i][1]) begin
        wr(CLK_CTRL_ADDR, sl[i][23:16]);
        if (i == 0) begin
          u_imp_bus_model.m_byte(8'h3c, ack);
          rr(DATA_ADDR, rd);
          check(rd, 8'h3c);
          wr(CLK_CTRL_ADDR, sl[i][23:16]);
        end
      end
      u_imp_bus_model.m_stop();
      rr(BUS_STAT_ADDR, rd);
      check(rd[2:1], 2'b00);
    end
    // Start request while another master already holds the bus
    wr(BUS_STAT_ADDR, 8'hc0);
    u_imp_bus_model.m_start();
    wr(BUS_STAT_ADDR, 8'hd0);
    wr(BUS_STAT_ADDR, 8'hf0);
    rr(BUS_STAT_ADDR, rd);
    check({rd[BS_BUSY], rd[BS_ARB]}, 2'b11);
    u_imp_bus_model.m_stop();
    wr(CLK_CTRL_ADDR, 8'h55);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    rr(CLK_CTRL_ADDR, rd);
    check(rd, 8'h0f);
    rr(BUS_STAT_ADDR, rd);
    check({irq_req, rd}, 9'h000);
    print_verdict();
  end
endmodule : testbench
